// ### verif/blsba_alu_tb.sv
// Self-checking bench for the byte logic/shift/bit datapath.
// Assumes the package and header from verilog/ are compiled first.
`timescale 1ns/1ps
`include "blsba_regs.svh"

module blsba_alu_tb;
    // m = {use_imm, pos_from_reg, carry_in}; x = {carry, check_z, z}
    typedef struct {
        blsba_pkg::blsba_op_type op;
        logic [7:0] a;
        logic [7:0] b;
        logic [2:0] m;
        logic [7:0] ed;
        logic [2:0] x;
    } blsba_row_type;

    logic i_clk = 1'h0;
    logic i_reset = 1'h1;
    blsba_pkg::blsba_req_type i_req = '0;
    blsba_pkg::blsba_load_type i_load = '0;
    logic [3:0] i_rd_idx = 4'h1;
    logic i_mem_rvalid = 1'h0;
    logic [7:0] i_mem_rdata = 8'h00;
    blsba_pkg::blsba_mem_type o_mem;
    blsba_pkg::blsba_flags_type o_flags;
    blsba_pkg::blsba_done_type o_done;
    logic [7:0] o_rd_data;
    logic o_busy;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int stall = 0;
    int wr_cnt = 0;
    logic [7:0] mem_byte = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic [15:0] wr_addr = 16'h0000;
    logic ill;

    blsba_row_type rows[31] = '{
        '{blsba_pkg::logic_and_op, 8'h96, 8'h3c, 3'h1, 8'h14, 3'h6},
        '{blsba_pkg::logic_and_op, 8'hf0, 8'h0f, 3'h4, 8'h00, 3'h3},
        '{blsba_pkg::logic_or_op, 8'h96, 8'h41, 3'h4, 8'hd7, 3'h2},
        '{blsba_pkg::logic_xor_op, 8'h96, 8'h3c, 3'h1, 8'haa, 3'h6},
        '{blsba_pkg::logic_not_op, 8'h96, 8'h00, 3'h0, 8'h69, 3'h2},
        '{blsba_pkg::arith_shift_left_op, 8'h96, 8'h00, 3'h0, 8'h2c, 3'h6},
        '{blsba_pkg::arith_shift_left_op, 8'h80, 8'h00, 3'h0, 8'h00, 3'h7},
        '{blsba_pkg::arith_shift_right_op, 8'h96, 8'h00, 3'h0, 8'hcb, 3'h2},
        '{blsba_pkg::logic_shift_left_op, 8'h5a, 8'h00, 3'h0, 8'hb4, 3'h2},
        '{blsba_pkg::logic_shift_right_op, 8'h81, 8'h00, 3'h0, 8'h40, 3'h6},
        '{blsba_pkg::rotate_left_op, 8'h96, 8'h00, 3'h0, 8'h2d, 3'h6},
        '{blsba_pkg::rotate_right_op, 8'h81, 8'h00, 3'h0, 8'hc0, 3'h6},
        '{blsba_pkg::rotate_left_carry_op, 8'h16, 8'h00, 3'h1, 8'h2d, 3'h2},
        '{blsba_pkg::rotate_right_carry_op, 8'h96, 8'h00, 3'h1, 8'hcb, 3'h2},
        '{blsba_pkg::bit_force_one_op, 8'h96, 8'h00, 3'h4, 8'h97, 3'h0},
        '{blsba_pkg::bit_force_one_op, 8'h96, 8'h0b, 3'h2, 8'h9e, 3'h0},
        '{blsba_pkg::bit_force_zero_op, 8'h96, 8'h07, 3'h5, 8'h16, 3'h4},
        '{blsba_pkg::bit_toggle_op, 8'h96, 8'h01, 3'h4, 8'h94, 3'h0},
        '{blsba_pkg::bit_toggle_op, 8'h96, 8'h03, 3'h2, 8'h9e, 3'h0},
        '{blsba_pkg::bit_probe_op, 8'h96, 8'h01, 3'h4, 8'h96, 3'h2},
        '{blsba_pkg::bit_probe_op, 8'h96, 8'h00, 3'h5, 8'h96, 3'h7},
        '{blsba_pkg::carry_and_bit_op, 8'h96, 8'h02, 3'h5, 8'h96, 3'h4},
        '{blsba_pkg::carry_and_inv_bit_op, 8'h96, 8'h02, 3'h5, 8'h96, 3'h0},
        '{blsba_pkg::carry_or_inv_bit_op, 8'h96, 8'h00, 3'h4, 8'h96, 3'h4},
        '{blsba_pkg::carry_or_bit_op, 8'h96, 8'h02, 3'h4, 8'h96, 3'h4},
        '{blsba_pkg::carry_xor_bit_op, 8'h96, 8'h04, 3'h5, 8'h96, 3'h0},
        '{blsba_pkg::carry_xor_inv_bit_op, 8'h96, 8'h04, 3'h5, 8'h96, 3'h4},
        '{blsba_pkg::bit_to_carry_op, 8'h96, 8'h07, 3'h4, 8'h96, 3'h4},
        '{blsba_pkg::inv_bit_to_carry_op, 8'h96, 8'h07, 3'h5, 8'h96, 3'h0},
        '{blsba_pkg::carry_to_bit_op, 8'h96, 8'h00, 3'h5, 8'h97, 3'h4},
        '{blsba_pkg::inv_carry_to_bit_op, 8'h96, 8'h02, 3'h5, 8'h92, 3'h4}
    };

    blsba_pkg::blsba_op_type bad[6] = '{blsba_pkg::carry_and_inv_bit_op,
        blsba_pkg::carry_or_inv_bit_op, blsba_pkg::carry_xor_inv_bit_op,
        blsba_pkg::inv_bit_to_carry_op, blsba_pkg::inv_carry_to_bit_op,
        blsba_pkg::logic_and_op};

    blsba_alu dut (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_req(i_req),
        .i_load(i_load),
        .i_rd_idx(i_rd_idx),
        .i_mem_rvalid(i_mem_rvalid),
        .i_mem_rdata(i_mem_rdata),
        .o_mem(o_mem),
        .o_flags(o_flags),
        .o_done(o_done),
        .o_rd_data(o_rd_data),
        .o_busy(o_busy)
    );

    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;

    // Memory side: answers a read after a stall; data line is junk outside rvalid
    always @(posedge i_clk) begin
        i_mem_rvalid <= 1'h0;
        i_mem_rdata <= ~mem_byte;
        if (o_mem.rd && !i_mem_rvalid) begin
            if (stall == 3) begin
                i_mem_rvalid <= 1'h1;
                i_mem_rdata <= mem_byte;
                stall <= 0;
            end else begin
                stall <= stall + 1;
            end
        end
        if (o_mem.wr) begin
            wr_cnt <= wr_cnt + 1;
            wr_data <= o_mem.wdata;
            wr_addr <= o_mem.addr;
        end
    end

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic load(input logic [3:0] idx, input logic [7:0] d, input logic c);
        @(posedge i_clk);
        i_load <= '{valid: 1'h1, idx: idx, data: d, c_we: 1'h1, c: c};
        @(posedge i_clk);
        i_load <= '0;
    endtask : load

    // Imm gets ~b when unused, so a wrong operand source shows up
    task automatic issue(input blsba_pkg::blsba_op_type o, input logic [7:0] b,
                         input logic [2:0] m, input logic mem);
        int n;
        n = 0;
        @(posedge i_clk);
        i_req <= '{valid: 1'h1, op: o, dst: 4'h1, src: 4'h2, imm: (m[2] ? b : ~b),
                   use_imm: m[2], pos_from_reg: m[1], mem: mem, addr: 16'h1234};
        @(posedge i_clk);
        i_req.valid <= 1'h0;
        #1;
        while (o_done.done !== 1'h1 && n < 50) begin
            @(posedge i_clk);
            #1;
            n = n + 1;
        end
        chk(o_done.done, 1'h1);
        ill = o_done.illegal;
        @(posedge i_clk);
        #1;
    endtask : issue

    task automatic mem_op(input blsba_pkg::blsba_op_type o, input logic [7:0] pos,
                          input logic [7:0] rd, input logic [7:0] wexp, input int wn);
        int w0;
        w0 = wr_cnt;
        mem_byte = rd;
        issue(o, pos, 3'h4, 1'h1);
        chk(8'(wr_cnt - w0), 8'(wn));
        if (wn == 1) begin
            chk(wr_data, wexp);
            chk(wr_addr[7:0], 8'h34);
        end
        chk(o_busy, 1'h0);
    endtask : mem_op

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (4) @(posedge i_clk);
        i_reset <= 1'h0;
        @(posedge i_clk);
        #1;
        chk({o_flags, o_busy, o_done, o_rd_data[0]}, 8'h00);
        $display("reset test done");
        // Table cases: operand in reg 1, second operand or position in reg 2
        foreach (rows[k]) begin
            load(4'h2, rows[k].b, 1'h0);
            load(4'h1, rows[k].a, rows[k].m[0]);
            issue(rows[k].op, rows[k].b, rows[k].m, 1'h0);
            chk(ill, 1'h0);
            chk(o_rd_data, rows[k].ed);
            chk(o_flags.c, rows[k].x[2]);
            if (rows[k].x[1]) chk(o_flags.z, rows[k].x[0]);
            if (rows[k].op < blsba_pkg::bit_force_one_op) begin
                chk({o_flags.n, o_flags.v}, {rows[k].ed[7], 1'h0});
            end
        end
        $display("table test done");
        // Inverting ops with register position, and a memory logic op, are refused
        load(4'h1, 8'h96, 1'h0);
        foreach (bad[k]) begin
            issue(bad[k], 8'h02, (k == 5) ? 3'h0 : 3'h2, k == 5);
            chk(ill, 1'h1);
            chk(o_rd_data, 8'h96);
        end
        $display("refusal test done");
        // Back to back requests on one register
        @(posedge i_clk);
        i_req <= '{valid: 1'h1, op: blsba_pkg::logic_xor_op, dst: 4'h1, src: 4'h2,
                   imm: 8'hff, use_imm: 1'h1, pos_from_reg: 1'h0, mem: 1'h0, addr: 16'h0};
        @(posedge i_clk);
        i_req.imm <= 8'h0f;
        issue(blsba_pkg::bit_probe_op, 8'h00, 3'h4, 1'h0);
        chk(o_rd_data, 8'h66);
        $display("back to back test done");
        // Memory read-modify-write, and a probe that must not write
        mem_op(blsba_pkg::bit_force_one_op, 8'h05, 8'h0f, 8'h2f, 1);
        mem_op(blsba_pkg::bit_toggle_op, 8'h00, 8'h0f, 8'h0e, 1);
        mem_op(blsba_pkg::bit_probe_op, 8'h05, 8'h0f, 8'h00, 0);
        chk(o_flags.z, 1'h1);
        $display("memory test done");
        end_sim();
    end
endmodule : blsba_alu_tb

// ### verilog/blsba_alu.sv
// Byte logic, shift, rotate and bit datapath with its own byte register file.
// Assumes one request at a time, taken only while o_busy is low, and a
// memory port that answers a read with i_mem_rvalid and takes a write at once.
`timescale 1ns/1ps
`include "blsba_regs.svh"

module blsba_alu (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire blsba_pkg::blsba_req_type i_req,
    input wire blsba_pkg::blsba_load_type i_load,
    input wire logic [`BLSBA_IDX_W-1:0] i_rd_idx,
    input wire logic i_mem_rvalid,
    input wire logic [`BLSBA_DATA_W-1:0] i_mem_rdata,
    output blsba_pkg::blsba_mem_type o_mem,
    output blsba_pkg::blsba_flags_type o_flags,
    output blsba_pkg::blsba_done_type o_done,
    output logic [`BLSBA_DATA_W-1:0] o_rd_data,
    output logic o_busy
);
    logic [`BLSBA_DATA_W-1:0] reg_file_ff [`BLSBA_NREG];
    blsba_pkg::blsba_state_type state_ff;
    blsba_pkg::blsba_state_type nxt_state;
    blsba_pkg::blsba_req_type req_ff;
    blsba_pkg::blsba_flags_type flags_ff;
    blsba_pkg::blsba_mem_type mem_ff;
    blsba_pkg::blsba_done_type done_ff;
    logic [`BLSBA_DATA_W-1:0] rd_data_ff;
    logic busy_ff;

    blsba_pkg::blsba_req_type cur;
    logic [`BLSBA_DATA_W-1:0] opnd;
    logic [`BLSBA_DATA_W-1:0] srcv;
    logic [`BLSBA_POS_W-1:0] pos;
    logic [`BLSBA_DATA_W:0] alu_out;
    logic [`BLSBA_DATA_W-1:0] bit_byte;
    logic bit_c;
    logic bit_z;
    logic bit_byte_we;
    logic bit_c_we;
    logic bit_z_we;
    logic take;
    logic illegal;
    logic exec;
    logic [`BLSBA_DATA_W-1:0] result;
    logic byte_we;

    // Inverting bit variants
    function automatic logic is_inv(input blsba_pkg::blsba_op_type op);
        case (op)
            blsba_pkg::carry_and_inv_bit_op,
            blsba_pkg::carry_or_inv_bit_op,
            blsba_pkg::carry_xor_inv_bit_op,
            blsba_pkg::inv_bit_to_carry_op,
            blsba_pkg::inv_carry_to_bit_op: is_inv = 1'b1;
            default: is_inv = 1'b0;
        endcase
    endfunction : is_inv

    // Bit instructions occupy the upper part of the opcode space
    function automatic logic is_bit(input blsba_pkg::blsba_op_type op);
        is_bit = (op >= blsba_pkg::bit_force_one_op);
    endfunction : is_bit

    // Shifts and rotates load carry with the bit pushed out
    function automatic logic is_shift(input blsba_pkg::blsba_op_type op);
        is_shift = (op >= blsba_pkg::arith_shift_left_op) &&
            (op <= blsba_pkg::rotate_right_carry_op);
    endfunction : is_shift

    // Byte result with carry out in the top bit
    function automatic logic [`BLSBA_DATA_W:0] alu_byte(
        input blsba_pkg::blsba_op_type op,
        input logic [`BLSBA_DATA_W-1:0] d,
        input logic [`BLSBA_DATA_W-1:0] s,
        input logic c
    );
        case (op)
            blsba_pkg::logic_and_op: alu_byte = {c, d & s}; // RQ1
            blsba_pkg::logic_or_op: alu_byte = {c, d | s}; // RQ2
            blsba_pkg::logic_xor_op: alu_byte = {c, d ^ s}; // RQ3
            blsba_pkg::logic_not_op: alu_byte = {c, ~d}; // RQ4
            blsba_pkg::arith_shift_left_op,
            blsba_pkg::logic_shift_left_op: alu_byte = {d, 1'b0}; // RQ5 RQ6
            blsba_pkg::arith_shift_right_op:
                alu_byte = {d[0], d[`BLSBA_MSB], d[`BLSBA_MSB:1]}; // RQ5
            blsba_pkg::logic_shift_right_op:
                alu_byte = {d[0], 1'b0, d[`BLSBA_MSB:1]}; // RQ6
            blsba_pkg::rotate_left_op:
                alu_byte = {d, d[`BLSBA_MSB]}; // RQ7
            blsba_pkg::rotate_right_op:
                alu_byte = {d[0], d[0], d[`BLSBA_MSB:1]}; // RQ7
            blsba_pkg::rotate_left_carry_op:
                alu_byte = {d, c}; // RQ8
            blsba_pkg::rotate_right_carry_op:
                alu_byte = {d[0], c, d[`BLSBA_MSB:1]}; // RQ8
            default: alu_byte = {c, d};
        endcase
    endfunction : alu_byte

    // Live request while idle, latched one while a memory access runs
    assign cur = (state_ff == blsba_pkg::st_idle) ? i_req : req_ff;
    assign opnd = (state_ff == blsba_pkg::st_idle) ? reg_file_ff[cur.dst] : i_mem_rdata;
    assign srcv = cur.use_imm ? cur.imm : reg_file_ff[cur.src];
    assign pos = cur.pos_from_reg ? reg_file_ff[cur.src][`BLSBA_POS_W-1:0]
        : cur.imm[`BLSBA_POS_W-1:0]; // RQ9

    // Register position on an inverting variant is refused; memory only for bits
    assign illegal = (is_inv(cur.op) && cur.pos_from_reg) || // RQ19
        (cur.mem && !is_bit(cur.op));
    assign take = (state_ff == blsba_pkg::st_idle) && i_req.valid;
    assign exec = (take && !illegal && !i_req.mem) ||
        ((state_ff == blsba_pkg::st_read) && i_mem_rvalid);

    assign alu_out = alu_byte(cur.op, opnd, srcv, flags_ff.c);
    assign result = is_bit(cur.op) ? bit_byte : alu_out[`BLSBA_DATA_W-1:0];
    assign byte_we = is_bit(cur.op) ? bit_byte_we : 1'b1;

    blsba_bit_unit u_bit (
        .i_op(cur.op),
        .i_byte(opnd),
        .i_pos(pos),
        .i_c(flags_ff.c),
        .o_byte(bit_byte),
        .o_c(bit_c),
        .o_z(bit_z),
        .o_byte_we(bit_byte_we),
        .o_c_we(bit_c_we),
        .o_z_we(bit_z_we)
    );

    // Sequencer: register ops finish in one cycle, memory bit ops read first
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            blsba_pkg::st_idle: begin
                if (take && !illegal && i_req.mem) begin
                    nxt_state = blsba_pkg::st_read; // RQ20
                end
            end
            blsba_pkg::st_read: begin
                if (i_mem_rvalid) begin
                    nxt_state = bit_byte_we ? blsba_pkg::st_write : blsba_pkg::st_idle;
                end
            end
            blsba_pkg::st_write: begin
                nxt_state = blsba_pkg::st_idle;
            end
            default: begin
                nxt_state = blsba_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_ff <= blsba_pkg::st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Request held for the length of a memory access
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            req_ff <= '0;
        end else if (take) begin
            req_ff <= i_req;
        end
    end

    // Busy mirrors the next state so it comes from a flop
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= (nxt_state != blsba_pkg::st_idle);
        end
    end

    // Memory port: read held until data, write for exactly one cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mem_ff <= '0;
        end else begin
            mem_ff.wr <= 1'b0;
            if (take && !illegal && i_req.mem) begin
                mem_ff.rd <= 1'b1; // RQ20
                mem_ff.addr <= i_req.addr;
            end else if ((state_ff == blsba_pkg::st_read) && i_mem_rvalid) begin
                mem_ff.rd <= 1'b0;
                if (bit_byte_we) begin
                    mem_ff.wr <= 1'b1; // RQ20
                    mem_ff.wdata <= bit_byte;
                end
            end
        end
    end

    // Register file; a load on the same cycle as a write-back loses
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int i = 0; i < `BLSBA_NREG; i++) begin
                reg_file_ff[i] <= `BLSBA_BYTE_ZERO;
            end
        end else if (exec && !cur.mem && byte_we) begin
            reg_file_ff[cur.dst] <= result; // RQ1 RQ4 RQ5 RQ7
        end else if (i_load.valid) begin
            reg_file_ff[i_load.idx] <= i_load.data;
        end
    end

    // Flags: each instruction touches only the flags it names, except that non-bit ops also clear V
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            flags_ff <= `BLSBA_FLAGS_RST;
        end else if (exec) begin
            if (!is_bit(cur.op)) begin
                flags_ff.n <= result[`BLSBA_MSB]; // RQ21
                flags_ff.z <= (result == `BLSBA_BYTE_ZERO); // RQ21
                flags_ff.v <= 1'b0;
                if (is_shift(cur.op)) begin
                    flags_ff.c <= alu_out[`BLSBA_DATA_W]; // RQ8
                end
            end else begin
                if (bit_c_we) begin
                    flags_ff.c <= bit_c; // RQ14 RQ17
                end
                if (bit_z_we) begin
                    flags_ff.z <= bit_z; // RQ13
                end
            end
        end else if (i_load.valid && i_load.c_we) begin
            flags_ff.c <= i_load.c;
        end
    end

    // Completion pulse, flagged when the request was refused
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            done_ff <= '0;
        end else begin
            done_ff.done <= (take && (illegal || !i_req.mem)) ||
                ((state_ff == blsba_pkg::st_read) && i_mem_rvalid && !bit_byte_we) ||
                (state_ff == blsba_pkg::st_write);
            done_ff.illegal <= take && illegal; // RQ19
        end
    end

    // Registered read port for software-visible register contents
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rd_data_ff <= `BLSBA_BYTE_ZERO;
        end else begin
            rd_data_ff <= reg_file_ff[i_rd_idx];
        end
    end

    assign o_mem = mem_ff;
    assign o_flags = flags_ff;
    assign o_done = done_ff;
    assign o_rd_data = rd_data_ff;
    assign o_busy = busy_ff;

    // Checks on the datapath results, refusals and the memory sequence
    a_and_result: assert property (@(posedge i_clk) disable iff (i_reset) // RQ1
        (exec && !cur.mem && cur.op == blsba_pkg::logic_and_op) |=>
        reg_file_ff[$past(cur.dst)] == ($past(opnd) & $past(srcv)))
        else $error("AND result wrong");

    a_or_result: assert property (@(posedge i_clk) disable iff (i_reset) // RQ2
        (exec && !cur.mem && cur.op == blsba_pkg::logic_or_op) |=>
        reg_file_ff[$past(cur.dst)] == ($past(opnd) | $past(srcv)))
        else $error("OR result wrong");

    a_xor_result: assert property (@(posedge i_clk) disable iff (i_reset) // RQ3
        (exec && !cur.mem && cur.op == blsba_pkg::logic_xor_op) |=>
        reg_file_ff[$past(cur.dst)] == ($past(opnd) ^ $past(srcv)))
        else $error("XOR result wrong");

    a_not_result: assert property (@(posedge i_clk) disable iff (i_reset) // RQ4
        (exec && !cur.mem && cur.op == blsba_pkg::logic_not_op) |=>
        reg_file_ff[$past(cur.dst)] == ~$past(opnd))
        else $error("complement wrong");

    a_sar_sign: assert property (@(posedge i_clk) disable iff (i_reset) // RQ5
        (exec && !cur.mem && cur.op == blsba_pkg::arith_shift_right_op) |=>
        reg_file_ff[$past(cur.dst)][`BLSBA_MSB] == $past(opnd[`BLSBA_MSB]) &&
        flags_ff.c == $past(opnd[0]))
        else $error("arithmetic right shift wrong");

    a_shr_logic: assert property (@(posedge i_clk) disable iff (i_reset) // RQ6
        (exec && !cur.mem && cur.op == blsba_pkg::logic_shift_right_op) |=>
        reg_file_ff[$past(cur.dst)] == ($past(opnd) >> 1))
        else $error("logical right shift wrong");

    a_rotate_left_op_loop: assert property (@(posedge i_clk) disable iff (i_reset) // RQ7
        (exec && !cur.mem && cur.op == blsba_pkg::rotate_left_op) |=>
        reg_file_ff[$past(cur.dst)][0] == $past(opnd[`BLSBA_MSB]))
        else $error("rotate left wrong");

    a_rotate_left_carry_op_carry: assert property (@(posedge i_clk) disable iff (i_reset) // RQ8
        (exec && !cur.mem && cur.op == blsba_pkg::rotate_left_carry_op) |=>
        reg_file_ff[$past(cur.dst)][0] == $past(flags_ff.c) &&
        flags_ff.c == $past(opnd[`BLSBA_MSB]))
        else $error("rotate through carry wrong");

    a_set_bit: assert property (@(posedge i_clk) disable iff (i_reset) // RQ10
        (exec && cur.op == blsba_pkg::bit_force_one_op) |->
        (bit_byte[pos] && ((bit_byte ^ opnd) & ~(`BLSBA_BYTE_ONE << pos)) == '0))
        else $error("bit set disturbs other bits");

    a_probe_z: assert property (@(posedge i_clk) disable iff (i_reset) // RQ13
        (exec && cur.op == blsba_pkg::bit_probe_op) |=>
        flags_ff.z == !$past(opnd[pos]) && $stable(flags_ff.c))
        else $error("bit test zero flag wrong");

    a_inv_refused: assert property (@(posedge i_clk) disable iff (i_reset) // RQ19
        (take && is_inv(i_req.op) && i_req.pos_from_reg) |=>
        o_done.done && o_done.illegal && $stable(flags_ff))
        else $error("register position accepted on inverting variant");

    a_rmw_write: assert property (@(posedge i_clk) disable iff (i_reset) // RQ20
        (state_ff == blsba_pkg::st_read && i_mem_rvalid && bit_byte_we) |=>
        o_mem.wr && !o_mem.rd ##1 !o_mem.wr && o_done.done)
        else $error("read-modify-write sequence broken");

endmodule : blsba_alu

// ### verilog/blsba_bit_unit.sv
// Single-bit operations on one byte and on the carry flag, combinational.
// Assumes the caller has already checked position source legality.
`timescale 1ns/1ps
`include "blsba_regs.svh"

module blsba_bit_unit (
    input wire blsba_pkg::blsba_op_type i_op,
    input wire logic [`BLSBA_DATA_W-1:0] i_byte,
    input wire logic [`BLSBA_POS_W-1:0] i_pos,
    input wire logic i_c,
    output logic [`BLSBA_DATA_W-1:0] o_byte,
    output logic o_c,
    output logic o_z,
    output logic o_byte_we,
    output logic o_c_we,
    output logic o_z_we
);
    logic [`BLSBA_DATA_W-1:0] mask;
    logic sel;

    // Mask from position; shifting a one keeps the decode in one place
    assign mask = `BLSBA_BYTE_ONE << i_pos; // RQ9
    assign sel = |(i_byte & mask);

    // Only the masked bit may differ from the input byte
    always_comb begin
        o_byte = i_byte;
        o_c = i_c;
        o_z = 1'b0;
        o_byte_we = 1'b0;
        o_c_we = 1'b0;
        o_z_we = 1'b0;
        case (i_op)
            blsba_pkg::bit_force_one_op: begin
                o_byte = i_byte | mask; // RQ10
                o_byte_we = 1'b1;
            end
            blsba_pkg::bit_force_zero_op: begin
                o_byte = i_byte & ~mask; // RQ11
                o_byte_we = 1'b1;
            end
            blsba_pkg::bit_toggle_op: begin
                o_byte = i_byte ^ mask; // RQ12
                o_byte_we = 1'b1;
            end
            blsba_pkg::bit_probe_op: begin
                o_z = ~sel; // RQ13
                o_z_we = 1'b1;
            end
            blsba_pkg::carry_and_bit_op: begin
                o_c = i_c & sel; // RQ14
                o_c_we = 1'b1;
            end
            blsba_pkg::carry_and_inv_bit_op: begin
                o_c = i_c & ~sel; // RQ14
                o_c_we = 1'b1;
            end
            blsba_pkg::carry_or_bit_op: begin
                o_c = i_c | sel; // RQ15
                o_c_we = 1'b1;
            end
            blsba_pkg::carry_or_inv_bit_op: begin
                o_c = i_c | ~sel; // RQ15
                o_c_we = 1'b1;
            end
            blsba_pkg::carry_xor_bit_op: begin
                o_c = i_c ^ sel; // RQ16
                o_c_we = 1'b1;
            end
            blsba_pkg::carry_xor_inv_bit_op: begin
                o_c = i_c ^ ~sel; // RQ16
                o_c_we = 1'b1;
            end
            blsba_pkg::bit_to_carry_op: begin
                o_c = sel; // RQ17
                o_c_we = 1'b1;
            end
            blsba_pkg::inv_bit_to_carry_op: begin
                o_c = ~sel; // RQ17
                o_c_we = 1'b1;
            end
            blsba_pkg::carry_to_bit_op: begin
                o_byte = i_c ? (i_byte | mask) : (i_byte & ~mask); // RQ18
                o_byte_we = 1'b1;
            end
            blsba_pkg::inv_carry_to_bit_op: begin
                o_byte = i_c ? (i_byte & ~mask) : (i_byte | mask); // RQ18
                o_byte_we = 1'b1;
            end
            default: begin
                o_byte = i_byte;
            end
        endcase
    end

endmodule : blsba_bit_unit

// ### verilog/blsba_pkg.sv
// Types shared by the datapath top and its bit unit.
// Assumes blsba_regs.svh is on the include path.
`include "blsba_regs.svh"

package blsba_pkg;

    typedef enum logic [4:0] {
        logic_and_op = 5'h00,
        logic_or_op = 5'h01,
        logic_xor_op = 5'h02,
        logic_not_op = 5'h03,
        arith_shift_left_op = 5'h04,
        arith_shift_right_op = 5'h05,
        logic_shift_left_op = 5'h06,
        logic_shift_right_op = 5'h07,
        rotate_left_op = 5'h08,
        rotate_right_op = 5'h09,
        rotate_left_carry_op = 5'h0a,
        rotate_right_carry_op = 5'h0b,
        bit_force_one_op = 5'h0c,
        bit_force_zero_op = 5'h0d,
        bit_toggle_op = 5'h0e,
        bit_probe_op = 5'h0f,
        carry_and_bit_op = 5'h10,
        carry_and_inv_bit_op = 5'h11,
        carry_or_bit_op = 5'h12,
        carry_or_inv_bit_op = 5'h13,
        carry_xor_bit_op = 5'h14,
        carry_xor_inv_bit_op = 5'h15,
        bit_to_carry_op = 5'h16,
        inv_bit_to_carry_op = 5'h17,
        carry_to_bit_op = 5'h18,
        inv_carry_to_bit_op = 5'h19
    } blsba_op_type;

    typedef enum logic [2:0] {
        st_idle = 3'h1,
        st_read = 3'h2,
        st_write = 3'h4
    } blsba_state_type;

    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } blsba_flags_type;

    typedef struct packed {
        logic valid;
        blsba_op_type op;
        logic [`BLSBA_IDX_W-1:0] dst;
        logic [`BLSBA_IDX_W-1:0] src;
        logic [`BLSBA_DATA_W-1:0] imm;
        logic use_imm;
        logic pos_from_reg;
        logic mem;
        logic [`BLSBA_ADDR_W-1:0] addr;
    } blsba_req_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [`BLSBA_ADDR_W-1:0] addr;
        logic [`BLSBA_DATA_W-1:0] wdata;
    } blsba_mem_type;

    typedef struct packed {
        logic valid;
        logic [`BLSBA_IDX_W-1:0] idx;
        logic [`BLSBA_DATA_W-1:0] data;
        logic c_we;
        logic c;
    } blsba_load_type;

    typedef struct packed {
        logic done;
        logic illegal;
    } blsba_done_type;

endpackage : blsba_pkg

// ### verilog/blsba_regs.svh
// Widths, reset values and bit constants for the byte logic/shift/bit datapath.
// Assumes inclusion by the package and by each design file; guarded.
// Function
// RQ1: AND destination with register or immediate
// RQ2: OR destination with register or immediate
// RQ3: XOR destination with register or immediate
// RQ4: Complement register, all bits inverted
// RQ5: Arithmetic shift register by one
// RQ6: Logical shift register by one
// RQ7: Rotate register by one, carry excluded
// RQ8: Rotate through carry as ninth bit
// RQ9: Bit position from immediate or register
// RQ10: Bit set forces one, rest kept
// RQ11: Bit clear forces zero, rest kept
// RQ12: Bit invert toggles selected bit only
// RQ13: Bit test loads zero flag inverted
// RQ14: Carry ANDed with bit or inverse
// RQ15: Carry ORed with bit or inverse
// RQ16: Carry XORed with bit or inverse
// RQ17: Bit or inverse copied into carry
// RQ18: Carry or inverse stored into bit
// RQ19: Inverting variants take immediate position only
// RQ20: Memory bit change is read-modify-write
// RQ21: Unnamed flags kept; logic sets N,Z (the code also clears V on every non-bit op)
`ifndef BLSBA_REGS_SVH
`define BLSBA_REGS_SVH

`define BLSBA_DATA_W 8
`define BLSBA_IDX_W 4
`define BLSBA_NREG 16
`define BLSBA_POS_W 3
`define BLSBA_ADDR_W 16
`define BLSBA_MSB 7
`define BLSBA_BYTE_ZERO 8'h00
`define BLSBA_BYTE_ONE 8'h01
`define BLSBA_FLAGS_RST 4'h0

`endif
